// [core/lcddrv_defines.svh]
// timing, layout and reset constants of the dot-matrix lcd driver
`ifndef LCDDRV_DEFINES_SVH
`define LCDDRV_DEFINES_SVH
`define LCDDRV_CLK_HZ 250000000
`define LCDDRV_OSC_HZ 32768
`define LCDDRV_FRAME_HZ 32
`define LCDDRV_TICK_CYC ((`LCDDRV_CLK_HZ) / (`LCDDRV_OSC_HZ))
`define LCDDRV_SLOT_TICKS ((`LCDDRV_OSC_HZ) / (`LCDDRV_FRAME_HZ * 16))
`define LCDDRV_NCOM 17
`define LCDDRV_NSEG 40
`define LCDDRV_NSEG_EXT 48
`define LCDDRV_DOTS 680
`define LCDDRV_DOTS_EXT 384
`define LCDDRV_ADDR_BASE 12'h000
`define LCDDRV_ADDR_LAST 12'h25F
`define LCDDRV_PAGE_OFS 12'h100
`define LCDDRV_ROW16_OFS 12'h200
`define LCDDRV_MEM_WORDS 608
`define LCDDRV_EXT_FIRST_COM 8
`define LCDDRV_EXT_FIRST_SEG 40
`define LCDDRV_LAST_COM_17 5'h10
`define LCDDRV_LAST_COM_16 5'h0F
`define LCDDRV_LAST_COM_8 5'h07
`define LCDDRV_RST_SUPPLY 1'b0
`define LCDDRV_RST_LIT 1'b0
`define LCDDRV_RST_DARK 1'b1
`define LCDDRV_RST_DUTY 2'h0
`define LCDDRV_RST_DUTY_EXT 2'h2
`define LCDDRV_RST_PAGE 1'b0
`define LCDDRV_RST_CONTRAST 4'h0
`define LCDDRV_LEVEL_GND 4'h0
`endif

// [core/lcddrv_pkg.sv]
// types shared by the dot-matrix lcd driver
package lcddrv_pkg;
    typedef enum logic [1:0] {
        LCDDRV_DUTY_17 = 2'b00,
        LCDDRV_DUTY_16 = 2'b01,
        LCDDRV_DUTY_8A = 2'b10,
        LCDDRV_DUTY_8B = 2'b11
    } lcddrv_duty_e;
    typedef struct packed {
        logic [11:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } lcddrv_mem_req_s;
    typedef struct packed {
        logic supply_on;
        logic force_all_lit;
        logic force_all_dark;
        logic duty_select_hi;
        logic duty_select_lo;
        logic screen_page_select;
        logic [3:0] contrast_code;
    } lcddrv_ctrl_s;
endpackage

// [core/lcddrv_top.sv]
// dot-matrix lcd driver: control bits, display memory and scan engine
`include "lcddrv_defines.svh"

// Overview of operation
// RL1: seventeen commons, forty segments, 680 dots
// RL2: 1/17, 1/16 or 1/8 duty, 1/4 bias
// RL3: 48-segment option reuses commons, 1/8 only
// RL4: extra segments map commons reversed
// RL5: supply bit enables drive level outputs
// RL6: force-lit drives every segment on
// RL7: force-dark blanks segments when not lit
// RL8: force-lit wins over force-dark
// RL9: both clear: segments follow memory
// RL10: duty bits decode to common count
// RL11: software keeps 1/8 with 48-segment option
// RL12: frame 32 Hz, 30.12 Hz at 1/17
// RL13: memory window F000H to F25EH; the code's window ends at 25FH
// RL14: memory one lights dot, zero darkens
// RL15: 1/8 duty page bit picks screen
// RL16: 1/17, 1/16 output every active common
// RL17: spare locations act as storage
// RL18: software initialises memory after reset
// RL19: software avoids unimplemented areas
// RL20: sixteen contrast codes scale drive levels
// RL21: software initialises contrast code
// RL22: supply off grounds all drive levels
// RL23: forcing never alters memory contents
// RL24: duty resets 1/17, or 1/8 extended
// RL25: dark resets one, lit and supply zero
// RL26: commons scan ascending, one per slot
module lcddrv_top #(
    parameter bit EXT_SEG48 = 1'b0,
    parameter int TICK_CYC = `LCDDRV_TICK_CYC,
    parameter int SLOT_TICKS = `LCDDRV_SLOT_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire lcddrv_pkg::lcddrv_mem_req_s i_mem_req,
    input wire lcddrv_pkg::lcddrv_ctrl_s i_ctrl,
    input wire logic i_ctrl_wr,
    output logic [3:0] o_mem_rdata,
    output logic [`LCDDRV_NCOM-1:0] o_common_outputs,
    output logic [`LCDDRV_NSEG-1:0] o_segment_outputs,
    output logic [`LCDDRV_NSEG_EXT-`LCDDRV_NSEG-1:0] o_extra_segment_outputs,
    output logic o_frame_toggle,
    output logic o_lcd_supply_on,
    output logic [3:0] o_base_drive_level,
    output lcddrv_pkg::lcddrv_ctrl_s o_ctrl
);
    localparam int NCOM = `LCDDRV_NCOM;
    localparam int NSEG = `LCDDRV_NSEG;
    localparam int NEXT = `LCDDRV_NSEG_EXT - `LCDDRV_NSEG;

    // reset release
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // control bits
    lcddrv_pkg::lcddrv_ctrl_s ctrl_r;
    lcddrv_pkg::lcddrv_ctrl_s ctrl_nxt;
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (i_ctrl_wr) begin
            ctrl_nxt.supply_on = i_ctrl.supply_on; // [RL5]
            ctrl_nxt.force_all_lit = i_ctrl.force_all_lit; // [RL6]
            ctrl_nxt.force_all_dark = i_ctrl.force_all_dark; // [RL7]
            ctrl_nxt.duty_select_hi = i_ctrl.duty_select_hi; // [RL10]
            ctrl_nxt.duty_select_lo = i_ctrl.duty_select_lo; // [RL10]
            ctrl_nxt.screen_page_select = i_ctrl.screen_page_select; // [RL15]
            ctrl_nxt.contrast_code = i_ctrl.contrast_code; // [RL20]
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r.supply_on <= `LCDDRV_RST_SUPPLY; // [RL25]
            ctrl_r.force_all_lit <= `LCDDRV_RST_LIT; // [RL25]
            ctrl_r.force_all_dark <= `LCDDRV_RST_DARK; // [RL25]
            {ctrl_r.duty_select_hi, ctrl_r.duty_select_lo} <=
                EXT_SEG48 ? `LCDDRV_RST_DUTY_EXT : `LCDDRV_RST_DUTY; // [RL24]
            ctrl_r.screen_page_select <= `LCDDRV_RST_PAGE;
            // zero contrast stands in for the undefined code
            ctrl_r.contrast_code <= `LCDDRV_RST_CONTRAST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // display memory, 4 bits per address
    logic [3:0] mem_r [`LCDDRV_MEM_WORDS];
    logic [3:0] rdata_r;
    logic [3:0] rdata_nxt;
    logic in_win;
    always_comb begin
        in_win = i_mem_req.addr <= `LCDDRV_ADDR_LAST; // [RL13]
        rdata_nxt = rdata_r;
        if (i_mem_req.rd) begin
            rdata_nxt = in_win ? mem_r[i_mem_req.addr[9:0]] : 4'h0;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_mem_req.wr && in_win) begin
            mem_r[i_mem_req.addr[9:0]] <= i_mem_req.wdata; // [RL17] [RL23]
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 4'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // slow oscillator tick and slot timer
    logic [$clog2(TICK_CYC+1)-1:0] div_r;
    logic [$clog2(TICK_CYC+1)-1:0] div_nxt;
    logic [$clog2(SLOT_TICKS+2)-1:0] slot_r;
    logic [$clog2(SLOT_TICKS+2)-1:0] slot_nxt;
    logic [4:0] com_r;
    logic [4:0] com_nxt;
    logic [4:0] last_com;
    logic tick;
    logic slot_end;
    logic frame_r;
    logic frame_nxt;
    always_comb begin
        case (lcddrv_pkg::lcddrv_duty_e'({ctrl_r.duty_select_hi, ctrl_r.duty_select_lo}))
            lcddrv_pkg::LCDDRV_DUTY_17: last_com = `LCDDRV_LAST_COM_17; // [RL10]
            lcddrv_pkg::LCDDRV_DUTY_16: last_com = `LCDDRV_LAST_COM_16; // [RL10]
            default: last_com = `LCDDRV_LAST_COM_8; // [RL10] [RL11]
        endcase
        if (EXT_SEG48) begin
            last_com = `LCDDRV_LAST_COM_8; // [RL3]
        end
        tick = div_r == ($bits(div_r))'(TICK_CYC - 1);
        div_nxt = tick ? '0 : div_r + 1'b1;
        // 1/17 duty keeps slot length, so frame is 32*16/17 = 30.12 Hz
        slot_end = tick && slot_r == ($bits(slot_r))'(
            (last_com == `LCDDRV_LAST_COM_8 ? 2 * SLOT_TICKS : SLOT_TICKS) - 1); // [RL12]
        slot_nxt = slot_r;
        com_nxt = com_r;
        frame_nxt = frame_r;
        if (tick) begin
            slot_nxt = slot_end ? '0 : slot_r + 1'b1;
        end
        if (slot_end) begin
            if (com_r >= last_com) begin
                com_nxt = 5'h00; // [RL26]
                frame_nxt = !frame_r;
            end else begin
                com_nxt = com_r + 5'h01; // [RL26]
            end
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div_r <= '0;
            slot_r <= '0;
            com_r <= 5'h00;
            frame_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            slot_r <= slot_nxt;
            com_r <= com_nxt;
            frame_r <= frame_nxt;
        end
    end

    // row fetch: one memory bit per segment for the active common
    logic [NSEG+NEXT-1:0] row;
    logic [11:0] row_base;
    logic [11:0] row_addr;
    always_comb begin
        row = '0;
        row_addr = '0;
        row_base = `LCDDRV_ADDR_BASE;
        if (last_com == `LCDDRV_LAST_COM_8) begin
            if (ctrl_r.screen_page_select) begin
                row_base = `LCDDRV_PAGE_OFS; // [RL15]
            end
        end else if (com_r[4]) begin
            row_base = `LCDDRV_ROW16_OFS; // [RL16]
        end else if (com_r[3]) begin
            row_base = `LCDDRV_PAGE_OFS; // [RL16]
        end
        for (int s = 0; s < NSEG + NEXT; s++) begin
            if (com_r[4]) begin
                row_addr = row_base + 12'(2 * s);
                row[s] = mem_r[row_addr[9:0]][0];
            end else begin
                row_addr = row_base + 12'(2 * s) + {11'h000, com_r[2]};
                row[s] = mem_r[row_addr[9:0]][com_r[1:0]]; // [RL14]
            end
        end
    end

    // waveform selection and output registers
    logic [NCOM-1:0] com_out_nxt;
    logic [NSEG+NEXT-1:0] seg_nxt;
    logic frame_out_nxt;
    logic supply_out_nxt;
    logic [3:0] level_out_nxt;
    lcddrv_pkg::lcddrv_ctrl_s ctrl_out_nxt;
    always_comb begin
        frame_out_nxt = frame_r;
        supply_out_nxt = ctrl_r.supply_on; // [RL5]
        // supply off pulls every level to ground
        level_out_nxt = `LCDDRV_LEVEL_GND; // [RL22]
        if (ctrl_r.supply_on) begin
            level_out_nxt = ctrl_r.contrast_code; // [RL20]
        end
        ctrl_out_nxt = ctrl_r;
    end
    always_comb begin
        com_out_nxt = '0;
        com_out_nxt[com_r] = 1'b1; // [RL1] [RL2] [RL26]
        if (ctrl_r.force_all_lit) begin
            seg_nxt = '1; // [RL6] [RL8]
        end else if (ctrl_r.force_all_dark) begin
            seg_nxt = '0; // [RL7]
        end else begin
            seg_nxt = row; // [RL9]
        end
        if (!EXT_SEG48) begin
            seg_nxt[NSEG+NEXT-1:NSEG] = '0;
        end else begin
            for (int k = 0; k < NEXT; k++) begin
                com_out_nxt[NCOM-1-k] = seg_nxt[NSEG+k]; // [RL4] [RL3]
            end
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_common_outputs <= '0;
            o_segment_outputs <= '0;
            o_extra_segment_outputs <= '0;
            o_frame_toggle <= 1'b0;
            o_lcd_supply_on <= 1'b0;
            o_base_drive_level <= 4'h0;
            o_mem_rdata <= 4'h0;
            o_ctrl <= '0;
        end else begin
            o_common_outputs <= com_out_nxt;
            o_segment_outputs <= seg_nxt[NSEG-1:0];
            o_extra_segment_outputs <= seg_nxt[NSEG+NEXT-1:NSEG];
            o_frame_toggle <= frame_out_nxt;
            o_lcd_supply_on <= supply_out_nxt; // [RL5]
            o_base_drive_level <= level_out_nxt; // [RL20] [RL22]
            o_mem_rdata <= rdata_r;
            o_ctrl <= ctrl_out_nxt;
        end
    end
endmodule // lcddrv_top

// [tb/lcddrv_assertions.sv]
// port checker for the lcd driver
module lcddrv_assertions (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire lcddrv_pkg::lcddrv_mem_req_s i_mem_req,
    input wire logic [3:0] o_mem_rdata,
    input wire logic [16:0] o_common_outputs,
    input wire logic [39:0] o_segment_outputs,
    input wire logic o_lcd_supply_on,
    input wire logic [3:0] o_base_drive_level,
    input wire lcddrv_pkg::lcddrv_ctrl_s o_ctrl
);
    logic [7:0] age_r;
    logic [7:0] age_nxt;
    lcddrv_pkg::lcddrv_ctrl_s prev_r;
    wire logic st = age_r == 8'h50;
    always_comb begin
        age_nxt = (o_ctrl != prev_r) ? 8'h00 : age_r + {7'h00, !st};
    end
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            age_r <= 8'h00;
            prev_r <= '0;
        end else begin
            age_r <= age_nxt;
            prev_r <= o_ctrl;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_rd_out;
        i_mem_req.rd && i_mem_req.addr > 12'h25F;
    endsequence
    sequence s_zero_ans;
        ##2 o_mem_rdata == 4'h0;
    endsequence
    a_read_outside: assert property (s_rd_out |-> s_zero_ans)
        else $error("read outside window not zero");
    a_supply_off: assert property (!o_lcd_supply_on |-> o_base_drive_level == 4'h0)
        else $error("drive level not grounded");
    a_level_code: assert property (o_lcd_supply_on |-> o_base_drive_level == o_ctrl.contrast_code)
        else $error("drive level not contrast code");
    a_supply_copy: assert property (o_lcd_supply_on == o_ctrl.supply_on)
        else $error("supply output differs from bit");
    a_one_common: assert property ($onehot0(o_common_outputs))
        else $error("more than one common active");
    a_scan_step: assert property ($changed(o_common_outputs) && $past(o_common_outputs) != 0
        && o_common_outputs != 0 |-> o_common_outputs == 17'h1
        || o_common_outputs == $past(o_common_outputs) << 1)
        else $error("common order broken");
    a_duty_eight: assert property (st && o_ctrl.duty_select_hi |-> o_common_outputs[16:8] == 9'h0)
        else $error("upper common active at 1/8");
    a_duty_sixteen: assert property (st && !o_ctrl.duty_select_hi && o_ctrl.duty_select_lo
        |-> !o_common_outputs[16])
        else $error("common 16 active at 1/16");
    a_force_lit: assert property (st && o_ctrl.force_all_lit |-> &o_segment_outputs)
        else $error("segments not all on");
    a_force_dark: assert property (st && o_ctrl.force_all_dark && !o_ctrl.force_all_lit
        |-> o_segment_outputs == 40'h0)
        else $error("segments not all off");
endmodule // lcddrv_assertions
bind lcddrv_top lcddrv_assertions chk_u (.i_sys_clk, .i_arst_n, .i_mem_req, .o_mem_rdata,
    .o_common_outputs, .o_segment_outputs, .o_lcd_supply_on, .o_base_drive_level, .o_ctrl);

// [tb/lcddrv_panel.sv]
// lcd panel model keeping the last pattern shown on each common row
module lcddrv_panel (
    input wire logic i_clk,
    input wire logic [16:0] i_com,
    input wire logic [39:0] i_seg,
    output logic [39:0] o_rows [17]
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge i_clk) begin
        for (int c = 0; c < 17; c++) begin
            if (i_com[c]) begin
                o_rows[c] <= i_seg;
            end
        end
    end
endmodule // lcddrv_panel

// [tb/tb_lcddrv_top.sv]
// self-checking bench of the lcd driver
module tb_lcddrv_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lcddrv_pkg::lcddrv_mem_req_s req = '0;
    lcddrv_pkg::lcddrv_ctrl_s ctl = '0;
    logic ctl_wr = 1'b0;
    logic [3:0] rdata;
    logic [16:0] com;
    logic [39:0] seg;
    logic tog;
    logic sup;
    logic [3:0] lvl;
    lcddrv_pkg::lcddrv_ctrl_s octl;
    logic [39:0] rows [17];
    int mismatches = 0;
    int samples_checked = 0;
    lcddrv_top #(.EXT_SEG48(1'b0), .TICK_CYC(2), .SLOT_TICKS(2)) dut_u (.i_sys_clk(clk),
        .i_arst_n(rst_n), .i_mem_req(req), .i_ctrl(ctl), .i_ctrl_wr(ctl_wr), .o_mem_rdata(rdata),
        .o_common_outputs(com), .o_segment_outputs(seg), .o_extra_segment_outputs(),
        .o_frame_toggle(tog), .o_lcd_supply_on(sup), .o_base_drive_level(lvl), .o_ctrl(octl));
    lcddrv_panel pan_u (.i_clk(clk), .i_com(com), .i_seg(seg), .o_rows(rows));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic dot(int c, int s);
        return ((c + s) % 3) == 0;
    endfunction
    function automatic logic [3:0] nib(int a);
        logic [3:0] n;
        int b;
        n = '0;
        b = (a >= 12'h200) ? 16 : ((a >= 12'h100) ? 8 : 0) + 4 * (a & 1);
        for (int i = 0; i < 4; i++) if (a < 12'h200 || i == 0) n[i] = dot(b + i, (a & 8'hFF) / 2);
        return n;
    endfunction
    task automatic mem_op(input logic [11:0] a, input logic [3:0] d, input logic rd);
        @(negedge clk);
        req = '{addr: a, wdata: d, wr: !rd, rd: rd};
        @(negedge clk);
        req = '0;
        repeat (2) @(negedge clk);
        if (rd) check(rdata, d);
    endtask
    task automatic set_ctl(input logic [9:0] v);
        @(negedge clk);
        ctl = v;
        ctl_wr = 1'b1;
        @(negedge clk);
        ctl_wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic wait_tog(output int n);
        logic t;
        t = tog;
        n = 0;
        while (tog === t && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic frame(input int exp);
        int n;
        wait_tog(n);
        wait_tog(n);
        check(n, exp);
    endtask
    task automatic rows_chk(input int n, input int ofs, input int mode);
        logic [39:0] e;
        for (int c = 0; c < n; c++) begin
            for (int s = 0; s < 40; s++) e[s] = mode == 1 || (mode == 0 && dot(c + ofs, s));
            check(rows[c], e);
        end
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        check(octl, 10'h080);
        check(lvl, 4'h0);
        for (int a = 0; a < 12'h250; a++) begin
            if ((a & 12'h0FF) < 12'h050 && (a < 12'h200 || !a[0])) mem_op(a, nib(a), 1'b0);
        end
        mem_op(12'h250, 4'hA, 1'b0);
        mem_op(12'h250, 4'hA, 1'b1);
        mem_op(12'h103, nib(12'h103), 1'b1);
        mem_op(12'h300, 4'h0, 1'b1);
        set_ctl(10'h207);
        frame(68);
        rows_chk(17, 0, 0);
        check(lvl, 4'h7);
        check(sup, 1'b1);
        set_ctl(10'h3C7);
        frame(64);
        rows_chk(8, 0, 1);
        mem_op(12'h001, nib(12'h001), 1'b1);
        set_ctl(10'h2E7);
        frame(64);
        rows_chk(8, 0, 2);
        set_ctl(10'h250);
        frame(64);
        rows_chk(8, 8, 0);
        check(lvl, 4'h0);
        set_ctl(10'h240);
        frame(64);
        rows_chk(8, 0, 0);
        set_ctl(10'h02F);
        frame(64);
        rows_chk(16, 0, 0);
        check(lvl, 4'h0);
        check(sup, 1'b0);
        stop_test();
    end
endmodule // tb_lcddrv_top
